// ### alr_regs.sv
// top: access control and latency report capability registers behind an axi4-lite slave
//
// Contract
// - access group downstream only, latency group upstream
// - access header id reads 000d, read-only
// - both headers report version 1
// - both headers point next to 240h
// - access capability bits 0..6 read one
// - egress vector size field reads 08h
// - seven access enables, writable, reset zero
// - egress vector writable, resets 00h, blocks peers
// - latency header id reads 0018
// - snoop latency value writable, resets zero
// - snoop latency scale writable, resets zero
//
// Design decision made here: the AXI4-Lite register port.
module alr_regs
  import alr_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // port role strap: high for the upstream port
  input  wire logic        is_upstream,
  // axi4-lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [11:0] s_axi_awaddr,
  // axi4-lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // axi4-lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [11:0] s_axi_araddr,
  // axi4-lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // controls toward the routing logic
  output logic [6:0]       acc_enable,
  output logic [7:0]       egress_block,
  output logic [9:0]       snoop_lat_value,
  output logic [2:0]       snoop_lat_scale
);
  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  logic [6:0]  acc_en_reg;
  logic [7:0]  egr_vec_reg;
  logic [9:0]  snoop_val_reg;
  logic [2:0]  snoop_scl_reg;
  logic        role_reg;
  logic [11:0] aw_addr_reg;
  logic        aw_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        w_held_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic [31:0] rdata_next;
  logic        wr_fire;
  logic        w_acc_cap;
  logic        w_egr_vec;
  logic        w_snoop;
  logic        w_any;
  logic        r_acc_hdr;
  logic        r_acc_cap;
  logic        r_egr_vec;
  logic        r_lat_hdr;
  logic        r_snoop;
  logic        r_any;

  // ------------------------------------------------------------
  // port role capture
  // ------------------------------------------------------------
  // role strap sampled every clock; no reset, the flop simply follows the pin
  always_ff @(posedge clk) begin
    role_reg <= is_upstream;
  end

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  alr_decode u_wdec (
    .addr        (aw_addr_reg),
    .is_upstream (role_reg),
    .hit_acc_hdr (),
    .hit_acc_cap (w_acc_cap),
    .hit_egr_vec (w_egr_vec),
    .hit_lat_hdr (),
    .hit_snoop   (w_snoop),
    .hit_any     (w_any)
  );

  alr_decode u_rdec (
    .addr        ({s_axi_araddr[11:2], 2'b00}),
    .is_upstream (role_reg),
    .hit_acc_hdr (r_acc_hdr),
    .hit_acc_cap (r_acc_cap),
    .hit_egr_vec (r_egr_vec),
    .hit_lat_hdr (r_lat_hdr),
    .hit_snoop   (r_snoop),
    .hit_any     (r_any)
  );

  // ------------------------------------------------------------
  // write channel capture
  // ------------------------------------------------------------
  // address and data taken in either order, held until the write commits
  assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= {s_axi_awaddr[11:2], 2'b00};
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  // ready flops: high while the slot is free
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !(aw_held_reg || (s_axi_awvalid && s_axi_awready)) || wr_fire;
      s_axi_wready  <= !(w_held_reg || (s_axi_wvalid && s_axi_wready)) || wr_fire;
    end
  end

  // ------------------------------------------------------------
  // writable fields, per byte lane; read-only fields have no flops
  // ------------------------------------------------------------
  // access enables live in lanes 2 (bits 22:16)
  always_ff @(posedge clk) begin
    if (rst) begin
      acc_en_reg <= ACC_EN_RST;
    end else if (wr_fire && w_acc_cap && w_strb_reg[2]) begin
      acc_en_reg <= w_data_reg[ACC_EN_LSB +: ACC_EN_W];
    end
  end

  // egress vector in lane 0
  always_ff @(posedge clk) begin
    if (rst) begin
      egr_vec_reg <= EGR_VEC_RST;
    end else if (wr_fire && w_egr_vec && w_strb_reg[0]) begin
      egr_vec_reg <= w_data_reg[EGR_VEC_W-1:0];
    end
  end

  // snoop latency value spans lanes 0 and 1, scale sits in lane 1
  always_ff @(posedge clk) begin
    if (rst) begin
      snoop_val_reg <= SNOOP_VAL_RST;
      snoop_scl_reg <= SNOOP_SCL_RST;
    end else if (wr_fire && w_snoop) begin
      if (w_strb_reg[0]) begin
        snoop_val_reg[7:0] <= w_data_reg[7:0];
      end
      if (w_strb_reg[1]) begin
        snoop_val_reg[9:8] <= w_data_reg[9:8];
        snoop_scl_reg      <= w_data_reg[SNOOP_SCL_LSB +: SNOOP_SCL_W];
      end
    end
  end

  // ------------------------------------------------------------
  // write response
  // ------------------------------------------------------------
  // unmapped or wrong-role addresses answer slverr and change nothing
  always_ff @(posedge clk) begin
    if (rst) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= w_any ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  // assemble the read word; every bit not named stays zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (r_acc_hdr) begin
      rdata_next = {NEXT_CAP_PTR, CAP_VERSION, ACC_CAP_ID};
    end else if (r_lat_hdr) begin
      rdata_next = {NEXT_CAP_PTR, CAP_VERSION, LAT_CAP_ID};
    end else if (r_acc_cap) begin
      rdata_next = {9'h000, acc_en_reg, EGR_VEC_SIZE, 1'b0, ACC_SUPPORT};
    end else if (r_egr_vec) begin
      rdata_next = {24'h000000, egr_vec_reg};
    end else if (r_snoop) begin
      rdata_next = {19'h00000, snoop_scl_reg, snoop_val_reg};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !rvalid_reg && !(s_axi_arvalid && s_axi_arready);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rdata_next;
      rresp_reg  <= r_any ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign s_axi_bvalid    = bvalid_reg;
  assign s_axi_bresp     = bresp_reg;
  assign s_axi_rvalid    = rvalid_reg;
  assign s_axi_rdata     = rdata_reg;
  assign s_axi_rresp     = rresp_reg;
  assign acc_enable      = acc_en_reg;
  assign egress_block    = egr_vec_reg;
  assign snoop_lat_value = snoop_val_reg;
  assign snoop_lat_scale = snoop_scl_reg;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence rd_taken_s(logic [11:0] a);
    s_axi_arvalid && s_axi_arready && s_axi_araddr == a && !role_reg;
  endsequence

  sequence rd_lat_s(logic [11:0] a);
    s_axi_arvalid && s_axi_arready && s_axi_araddr == a && role_reg;
  endsequence

  acc_hdr_read_a: assert property (@(posedge clk) disable iff (rst)
    rd_taken_s(ACC_HDR_OFF) |=> s_axi_rvalid && s_axi_rdata[15:0] == 16'h000d)
    else $error("access header id wrong");

  hdr_version_a: assert property (@(posedge clk) disable iff (rst)
    (rd_taken_s(ACC_HDR_OFF) or rd_lat_s(LAT_HDR_OFF)) |=> s_axi_rdata[19:16] == 4'h1)
    else $error("header version wrong");

  hdr_next_ptr_a: assert property (@(posedge clk) disable iff (rst)
    (rd_taken_s(ACC_HDR_OFF) or rd_lat_s(LAT_HDR_OFF)) |=> s_axi_rdata[31:20] == 12'h240)
    else $error("next pointer wrong");

  cap_bits_a: assert property (@(posedge clk) disable iff (rst)
    rd_taken_s(ACC_CAP_OFF) |=> s_axi_rdata[7:0] == 8'h7f && s_axi_rdata[15:8] == 8'h08)
    else $error("capability bits wrong");

  lat_hdr_read_a: assert property (@(posedge clk) disable iff (rst)
    rd_lat_s(LAT_HDR_OFF) |=> s_axi_rdata[15:0] == 16'h0018)
    else $error("latency header id wrong");

  role_gate_a: assert property (@(posedge clk) disable iff (rst)
    rd_lat_s(ACC_CAP_OFF) |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("access group visible upstream");

  enable_write_a: assert property (@(posedge clk) disable iff (rst)
    wr_fire && w_acc_cap && w_strb_reg[2] |=> acc_enable == $past(w_data_reg[22:16]))
    else $error("enable write lost");

  egress_write_a: assert property (@(posedge clk) disable iff (rst)
    wr_fire && w_egr_vec && w_strb_reg[0] |=> egress_block == $past(w_data_reg[7:0]))
    else $error("egress write lost");

  snoop_hold_a: assert property (@(posedge clk) disable iff (rst)
    !(wr_fire && w_snoop) |=> $stable(snoop_lat_value) && $stable(snoop_lat_scale))
    else $error("snoop latency changed without write");

  rsvd_zero_a: assert property (@(posedge clk) disable iff (rst)
    (rd_taken_s(ACC_CAP_OFF) or rd_taken_s(EGR_VEC_OFF) or rd_lat_s(SNOOP_LAT_OFF))
    |=> s_axi_rdata[31:23] == 9'h000)
    else $error("reserved bits nonzero");
endmodule

// ### alr_pkg.sv
// package: offsets, fields, reset values and fixed codes of the capability register bank
package alr_pkg;
  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [11:0] ACC_HDR_OFF   = 12'h220;
  localparam logic [11:0] ACC_CAP_OFF   = 12'h224;
  localparam logic [11:0] EGR_VEC_OFF   = 12'h228;
  localparam logic [11:0] LAT_HDR_OFF   = 12'h230;
  localparam logic [11:0] SNOOP_LAT_OFF = 12'h234;
  // ------------------------------------------------------------
  // fixed header fields
  // ------------------------------------------------------------
  localparam logic [15:0] ACC_CAP_ID    = 16'h000d;
  localparam logic [15:0] LAT_CAP_ID    = 16'h0018;
  localparam logic [3:0]  CAP_VERSION   = 4'h1;
  localparam logic [11:0] NEXT_CAP_PTR  = 12'h240;
  // ------------------------------------------------------------
  // capability word fields
  // ------------------------------------------------------------
  localparam logic [6:0]  ACC_SUPPORT   = 7'h7f;
  localparam logic [7:0]  EGR_VEC_SIZE  = 8'h08;
  localparam int          ACC_EN_LSB    = 16;
  localparam int          ACC_EN_W      = 7;
  localparam int          EGR_VEC_W     = 8;
  localparam int          SNOOP_VAL_W   = 10;
  localparam int          SNOOP_SCL_LSB = 10;
  localparam int          SNOOP_SCL_W   = 3;
  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [6:0]  ACC_EN_RST    = 7'h00;
  localparam logic [7:0]  EGR_VEC_RST   = 8'h00;
  localparam logic [9:0]  SNOOP_VAL_RST = 10'h000;
  localparam logic [2:0]  SNOOP_SCL_RST = 3'h0;
  // ------------------------------------------------------------
  // axi answers
  // ------------------------------------------------------------
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage

// ### alr_decode.sv
// address decode: maps a byte address to a register slot, honouring port role
module alr_decode
  import alr_pkg::*;
(
  // address and role
  input  wire logic [11:0] addr,
  input  wire logic        is_upstream,
  // decode result
  output logic             hit_acc_hdr,
  output logic             hit_acc_cap,
  output logic             hit_egr_vec,
  output logic             hit_lat_hdr,
  output logic             hit_snoop,
  output logic             hit_any
);
  // access control group only on downstream, latency group only on upstream
  always_comb begin
    hit_acc_hdr = !is_upstream && (addr == ACC_HDR_OFF);
    hit_acc_cap = !is_upstream && (addr == ACC_CAP_OFF);
    hit_egr_vec = !is_upstream && (addr == EGR_VEC_OFF);
    hit_lat_hdr = is_upstream && (addr == LAT_HDR_OFF);
    hit_snoop   = is_upstream && (addr == SNOOP_LAT_OFF);
    hit_any     = hit_acc_hdr | hit_acc_cap | hit_egr_vec | hit_lat_hdr | hit_snoop;
  end
endmodule

// ### alr_host_bfm.sv
// host model: axi4-lite master issuing single register accesses
module alr_host_bfm (
  // clock
  input  wire logic        clk,
  // write channels
  output logic             awvalid,
  input  wire logic        awready,
  output logic [11:0]      awaddr,
  output logic             wvalid,
  input  wire logic        wready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  input  wire logic        bvalid,
  output logic             bready,
  input  wire logic [1:0]  bresp,
  // read channels
  output logic             arvalid,
  input  wire logic        arready,
  output logic [11:0]      araddr,
  input  wire logic        rvalid,
  output logic             rready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle bus at time zero
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb} = 60'h0;
  end

  // one write: both halves offered together, each dropped and scrambled once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] resp, output bit hung);
    bit got;
    got = 1'b0;
    resp = 2'h3;
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    bready <= 1'b1;
    for (int n = 0; n < 40 && !got; n++) begin
      @(posedge clk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata <= ~d;
      end
      if (bvalid) begin
        resp = bresp;
        bready <= 1'b0;
        got = 1'b1;
      end
    end
    hung = !got;
  endtask

  // one read: address held until taken, data captured at the rvalid edge
  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    output logic [1:0] resp, output bit hung);
    bit got;
    got = 1'b0;
    d = 32'h0;
    resp = 2'h3;
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    for (int n = 0; n < 40 && !got; n++) begin
      @(posedge clk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
      if (rvalid) begin
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
        got = 1'b1;
      end
    end
    hung = !got;
  endtask
endmodule

// ### tb.sv
// testbench: capability register bank driven through the host model
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin mismatches++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb
  import alr_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst, is_upstream;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [6:0]  acc_enable;
  logic [7:0]  egress_block;
  logic [9:0]  snoop_lat_value;
  logic [2:0]  snoop_lat_scale;
  int          mismatches, checks_done;

  alr_host_bfm i_host (.clk, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
    .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready,
    .rdata, .rresp);

  alr_regs i_dut (.clk(clk), .rst(rst), .is_upstream(is_upstream),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .acc_enable(acc_enable), .egress_block(egress_block),
    .snoop_lat_value(snoop_lat_value), .snoop_lat_scale(snoop_lat_scale));

  // 50 ns clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // bus helpers: a hung handshake counts and ends the run
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    bit          h;
    i_host.rd(a, d, r, h);
    if (h) begin
      mismatches++;
      report_and_stop();
    end
    `CHK(d, ed)
    `CHK(r, er)
  endtask

  task automatic wr_chk(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] er);
    logic [1:0] r;
    bit         h;
    i_host.wr(a, d, s, r, h);
    if (h) begin
      mismatches++;
      report_and_stop();
    end
    `CHK(r, er)
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
  endtask

  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task automatic t_reset_values();
    rd_chk(ACC_HDR_OFF, 32'h2401000d, RESP_OKAY);
    rd_chk(ACC_CAP_OFF, 32'h0000087f, RESP_OKAY);
    rd_chk(EGR_VEC_OFF, 32'h00000000, RESP_OKAY);
    `CHK({acc_enable, egress_block}, 15'h0000)
    $display("test reset_values done");
  endtask

  task automatic t_acc_enables();
    logic [6:0] oh;
    for (int i = 0; i < 7; i++) begin
      oh = 7'h01 << i;
      wr_chk(ACC_CAP_OFF, {9'h1ff, oh, 16'hffff}, 4'hf, RESP_OKAY);
      rd_chk(ACC_CAP_OFF, {9'h000, oh, 16'h087f}, RESP_OKAY);
      `CHK(acc_enable, oh)
    end
    wr_chk(ACC_CAP_OFF, 32'h00000000, 4'hb, RESP_OKAY);
    `CHK(acc_enable, 7'h40)
    wr_chk(ACC_HDR_OFF, 32'hffffffff, 4'hf, RESP_OKAY);
    rd_chk(ACC_HDR_OFF, 32'h2401000d, RESP_OKAY);
    $display("test acc_enables done");
  endtask

  task automatic t_egress();
    wr_chk(EGR_VEC_OFF, 32'hffffff5a, 4'hf, RESP_OKAY);
    rd_chk(EGR_VEC_OFF, 32'h0000005a, RESP_OKAY);
    wr_chk(EGR_VEC_OFF, 32'h00000000, 4'he, RESP_OKAY);
    `CHK(egress_block, 8'h5a)
    rd_chk(LAT_HDR_OFF, 32'h00000000, RESP_SLVERR);
    wr_chk(SNOOP_LAT_OFF, 32'hffffffff, 4'hf, RESP_SLVERR);
    rd_chk(12'h22c, 32'h00000000, RESP_SLVERR);
    `CHK({snoop_lat_scale, snoop_lat_value}, 13'h0000)
    $display("test egress done");
  endtask

  task automatic t_upstream();
    @(posedge clk);
    is_upstream <= 1'b1;
    repeat (2) @(posedge clk);
    rd_chk(ACC_HDR_OFF, 32'h00000000, RESP_SLVERR);
    rd_chk(ACC_CAP_OFF, 32'h00000000, RESP_SLVERR);
    wr_chk(EGR_VEC_OFF, 32'h00000000, 4'hf, RESP_SLVERR);
    `CHK(egress_block, 8'h5a)
    rd_chk(LAT_HDR_OFF, 32'h24010018, RESP_OKAY);
    rd_chk(SNOOP_LAT_OFF, 32'h00000000, RESP_OKAY);
    wr_chk(SNOOP_LAT_OFF, 32'hffffffff, 4'hf, RESP_OKAY);
    rd_chk(SNOOP_LAT_OFF, 32'h00001fff, RESP_OKAY);
    wr_chk(SNOOP_LAT_OFF, 32'h0000e005, 4'h1, RESP_OKAY);
    rd_chk(SNOOP_LAT_OFF, 32'h00001f05, RESP_OKAY);
    `CHK({snoop_lat_scale, snoop_lat_value}, 13'h1f05)
    $display("test upstream done");
  endtask

  task automatic t_mid_reset();
    do_reset();
    rd_chk(SNOOP_LAT_OFF, 32'h00000000, RESP_OKAY);
    `CHK({acc_enable, egress_block, snoop_lat_scale, snoop_lat_value}, 28'h0)
    $display("test mid_reset done");
  endtask

  // main sequence
  initial begin
    rst = 1'b1;
    is_upstream = 1'b0;
    mismatches = 0;
    checks_done = 0;
    do_reset();
    t_reset_values();
    t_acc_enables();
    t_egress();
    t_upstream();
    t_mid_reset();
    report_and_stop();
  end
endmodule
